// >>> rtl/wdt_sleep_pkg.sv
`default_nettype none
package wdt_sleep_pkg;

    // register indices; byte address is four times the index
    localparam int unsigned    ADDR_W          = 16;
    localparam logic [15:0]    OPTION_IDX      = 16'h0081;
    localparam logic [15:0]    CONFIG_IDX      = 16'h2007;
    localparam logic [15:0]    STATUS_IDX      = 16'h0003;
    localparam logic [15:0]    OPTION_ADDR     = {OPTION_IDX[13:0], 2'b00};
    localparam logic [15:0]    CONFIG_ADDR     = {CONFIG_IDX[13:0], 2'b00};
    localparam logic [15:0]    STATUS_ADDR     = {STATUS_IDX[13:0], 2'b00};

    // option register fields
    localparam int unsigned    OPT_ASSIGN_BIT  = 3;
    localparam int unsigned    OPT_RATIO_LSB   = 0;
    localparam int unsigned    RATIO_W         = 3;
    localparam logic [7:0]     OPTION_RESET    = 8'hFF;

    // configuration word fields
    localparam int unsigned    CFG_ENABLE_BIT  = 2;
    localparam int unsigned    CFG_OSC_LSB     = 0;
    localparam logic [1:0]     OSC_MODE_RC     = 2'h3;

    // status register fields
    localparam int unsigned    STAT_EXPIRED_BIT = 4;
    localparam int unsigned    STAT_SLEPT_BIT   = 3;

    // timing
    localparam int unsigned    CLK_MHZ         = 50;
    localparam int unsigned    WDT_PERIOD_US   = 18000;
    localparam int unsigned    WDT_BASE_CYCLES = WDT_PERIOD_US * CLK_MHZ;
    localparam int unsigned    BASE_CNT_W      = 20;
    localparam int unsigned    OST_TOSC        = 1024;
    localparam int unsigned    OST_CYCLES      = OST_TOSC;
    localparam int unsigned    OST_CNT_W       = 11;

    // wake sources: external edge, port change, seven async peripherals
    localparam int unsigned    NUM_WAKE        = 9;
    localparam logic [12:0]    IRQ_VECTOR      = 13'h0004;

    localparam logic [1:0]     RESP_OKAY       = 2'h0;
    localparam logic [1:0]     RESP_SLVERR     = 2'h2;

    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SLEEP,
        PWR_OST,
        PWR_RESUME
    } pwr_state_t;

    typedef struct packed {
        logic expired;
        logic slept;
    } status_flags_t;

endpackage
`default_nettype wire

// >>> rtl/watchdog_sleep_wake_ctrl.sv
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none

module watchdog_sleep_wake_ctrl #(
    parameter int unsigned WDT_BASE_CYCLES_P = wdt_sleep_pkg::WDT_BASE_CYCLES
) (
    input  wire logic          clock,             // 50 MHz clock
    input  wire logic          rst_b,             // async reset, low
    // axi4-lite slave
    input  wire logic [15:0]   s_axi_awaddr,      // write address
    input  wire logic          s_axi_awvalid,     // write address valid
    output logic               s_axi_awready,     // write address ready
    input  wire logic [31:0]   s_axi_wdata,       // write data
    input  wire logic [3:0]    s_axi_wstrb,       // byte strobes
    input  wire logic          s_axi_wvalid,      // write data valid
    output logic               s_axi_wready,      // write data ready
    output logic [1:0]         s_axi_bresp,       // write response
    output logic               s_axi_bvalid,      // write response valid
    input  wire logic          s_axi_bready,      // write response ready
    input  wire logic [15:0]   s_axi_araddr,      // read address
    input  wire logic          s_axi_arvalid,     // read address valid
    output logic               s_axi_arready,     // read address ready
    output logic [31:0]        s_axi_rdata,       // read data
    output logic [1:0]         s_axi_rresp,       // read response
    output logic               s_axi_rvalid,      // read data valid
    input  wire logic          s_axi_rready,      // read data ready
    // core side
    input  wire logic [7:0]    config_word,       // nonvolatile fuses
    input  wire logic          kick_dog_instr,    // kick executes, pulse
    input  wire logic          sleep_instr,       // sleep executes, pulse
    input  wire logic          master_clear_pin_b,// external reset, low
    input  wire logic          global_irq_enable, // core global enable
    input  wire logic [8:0]    wake_irq_flags,    // wake-capable flags
    input  wire logic [8:0]    wake_irq_enables,  // matching enables
    output logic               device_reset,      // full device reset
    output logic               core_clk_run,      // core phase clocks on
    output logic               osc_drive_en,      // oscillator driver on
    output logic               io_hold,           // pins freeze drive
    output logic               prefetch_next,     // fetch pc+1, pulse
    output logic               resume_exec,       // execution resumes
    output logic               branch_to_vector,  // take irq vector
    output logic [12:0]        vector_addr,       // vector to load
    output logic               dog_expired_flag,  // status expired bit
    output logic               sleep_entered_flag // status slept bit
);

    ////////////////////////////////////////////////////////////////////
    // configuration capture and register state

    wdt_sleep_pkg::pwr_state_t    state_r;
    wdt_sleep_pkg::pwr_state_t    state_nxt;
    wdt_sleep_pkg::status_flags_t flags_r;
    wdt_sleep_pkg::status_flags_t flags_nxt;

    logic [7:0]   cfg_r;
    logic         cfg_loaded_r;
    logic [7:0]   option_r;
    logic [wdt_sleep_pkg::BASE_CNT_W-1:0] base_cnt_r;
    logic [7:0]   presc_cnt_r;
    logic [wdt_sleep_pkg::OST_CNT_W-1:0]  ost_cnt_r;
    logic         irq_wake_r;

    // fuses are caught after release, never by the reset itself
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cfg_r        <= 8'h00;
            cfg_loaded_r <= 1'b0;
        end else if (!cfg_loaded_r) begin
            cfg_r        <= config_word;
            cfg_loaded_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // watchdog time base

    wire dog_enable_fuse = cfg_loaded_r
                         & cfg_r[wdt_sleep_pkg::CFG_ENABLE_BIT];
    wire prescaler_assign_bit = option_r[wdt_sleep_pkg::OPT_ASSIGN_BIT];
    wire [2:0] prescale_ratio_sel =
        option_r[wdt_sleep_pkg::OPT_RATIO_LSB +: wdt_sleep_pkg::RATIO_W];
    wire [1:0] osc_mode = cfg_r[wdt_sleep_pkg::CFG_OSC_LSB +: 2];
    wire       crystal_mode = osc_mode != wdt_sleep_pkg::OSC_MODE_RC;

    wire [7:0] ratio_last = prescaler_assign_bit
                          ? 8'((9'h001 << prescale_ratio_sel) - 9'h001)
                          : 8'h00;

    localparam logic [wdt_sleep_pkg::BASE_CNT_W-1:0] BASE_LAST =
        wdt_sleep_pkg::BASE_CNT_W'(WDT_BASE_CYCLES_P - 1);
    wire base_tick = base_cnt_r == BASE_LAST;

    // only the nine clockless sources are wired in
    wire wake_pending = |(wake_irq_flags & wake_irq_enables);

    wire sleep_takes = (state_r == wdt_sleep_pkg::PWR_RUN)
                     & sleep_instr & ~wake_pending;
    wire kick = kick_dog_instr & (state_r == wdt_sleep_pkg::PWR_RUN);
    wire dog_clear = kick | sleep_takes;
    wire timeout = dog_enable_fuse & base_tick
                 & (presc_cnt_r == ratio_last) & ~dog_clear;
    wire pin_reset = ~master_clear_pin_b;
    // every cause that pins both dog counters at zero
    wire dog_hold = ~dog_enable_fuse | dog_clear | pin_reset;

    // counter runs on every clock, also while core is stopped
    // held at zero with the fuse cleared
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            base_cnt_r <= '0;
        end else if (dog_hold || base_tick) begin
            base_cnt_r <= '0;
        end else begin
            base_cnt_r <= base_cnt_r + 1'b1;
        end
    end

    // clearing touches only the count, option stays
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            presc_cnt_r <= 8'h00;
        end else if (dog_hold || timeout) begin
            presc_cnt_r <= 8'h00;
        end else if (base_tick) begin
            presc_cnt_r <= presc_cnt_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sleep and wake sequencer

    wire wake_event = timeout | wake_pending;
    wire ost_done = ost_cnt_r == wdt_sleep_pkg::OST_CNT_W'(
                    wdt_sleep_pkg::OST_CYCLES - 1);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            wdt_sleep_pkg::PWR_RUN: begin
                if (sleep_takes) begin
                    state_nxt = wdt_sleep_pkg::PWR_SLEEP;
                end
            end
            // a wake already pending leaves on the next edge
            wdt_sleep_pkg::PWR_SLEEP: begin
                if (wake_event) begin
                    // start-up wait only for crystal modes
                    state_nxt = crystal_mode ? wdt_sleep_pkg::PWR_OST
                                             : wdt_sleep_pkg::PWR_RESUME;
                end
            end
            wdt_sleep_pkg::PWR_OST: begin
                if (ost_done) begin
                    state_nxt = wdt_sleep_pkg::PWR_RESUME;
                end
            end
            wdt_sleep_pkg::PWR_RESUME: begin
                state_nxt = wdt_sleep_pkg::PWR_RUN;
            end
            default: begin
                state_nxt = wdt_sleep_pkg::PWR_RUN;
            end
        endcase
        if (pin_reset) begin
            state_nxt = wdt_sleep_pkg::PWR_RUN;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= wdt_sleep_pkg::PWR_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ost_cnt_r <= '0;
        end else if (state_r == wdt_sleep_pkg::PWR_OST) begin
            ost_cnt_r <= ost_cnt_r + 1'b1;
        end else begin
            ost_cnt_r <= '0;
        end
    end

    // remember whether an interrupt, not the dog, ended the sleep
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq_wake_r <= 1'b0;
        end else if (state_r == wdt_sleep_pkg::PWR_SLEEP && wake_event) begin
            irq_wake_r <= wake_pending;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status flags

    always_comb begin
        flags_nxt = flags_r;
        // sleep entry clears slept, sets expired
        // slept cleared only when sleep is taken, not with a wake pending
        if (sleep_takes) begin
            flags_nxt.slept   = 1'b0;
            flags_nxt.expired = 1'b1;
        end
        // a time-out always clears expired, and wins
        if (timeout) begin
            flags_nxt.expired = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            flags_r <= '{expired: 1'b1, slept: 1'b1};
        end else begin
            flags_r <= flags_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // core-facing outputs, all registered

    wire in_run_nxt = state_nxt == wdt_sleep_pkg::PWR_RUN
                    || state_nxt == wdt_sleep_pkg::PWR_RESUME;
    wire resume_nxt = state_nxt == wdt_sleep_pkg::PWR_RESUME;
    // rc wake leaves sleep on this edge, before irq_wake_r is loaded
    wire irq_wake_now = (state_r == wdt_sleep_pkg::PWR_SLEEP)
                      ? wake_pending
                      : irq_wake_r;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            device_reset       <= 1'b0;
            core_clk_run       <= 1'b1;
            osc_drive_en       <= 1'b1;
            io_hold            <= 1'b0;
            prefetch_next      <= 1'b0;
            resume_exec        <= 1'b0;
            branch_to_vector   <= 1'b0;
            vector_addr        <= 13'h0000;
            dog_expired_flag   <= 1'b1;
            sleep_entered_flag <= 1'b1;
        end else begin
            // running time-out resets; asleep it only wakes
            device_reset <= pin_reset
                          | (timeout & (state_r == wdt_sleep_pkg::PWR_RUN));
            core_clk_run <= in_run_nxt;
            osc_drive_en <= state_nxt != wdt_sleep_pkg::PWR_SLEEP;
            io_hold      <= ~in_run_nxt;
            // fetch of pc+1 during the sleep instruction
            prefetch_next <= sleep_takes;
            resume_exec  <= resume_nxt;
            // vector only for interrupt wake with global enable
            // wake itself never looked at the global enable
            branch_to_vector <= resume_nxt & irq_wake_now & global_irq_enable
                              & (state_r != wdt_sleep_pkg::PWR_RESUME);
            vector_addr  <= wdt_sleep_pkg::IRQ_VECTOR;
            dog_expired_flag   <= flags_nxt.expired;
            sleep_entered_flag <= flags_nxt.slept;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // axi4-lite slave, one write and one read at a time

    wire wr_fire = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
    wire rd_fire = s_axi_arready & s_axi_arvalid;

    wire wr_option = s_axi_awaddr == wdt_sleep_pkg::OPTION_ADDR;
    wire wr_known  = wr_option
                   || s_axi_awaddr == wdt_sleep_pkg::CONFIG_ADDR
                   || s_axi_awaddr == wdt_sleep_pkg::STATUS_ADDR;

    wire rd_option = s_axi_araddr == wdt_sleep_pkg::OPTION_ADDR;
    wire rd_config = s_axi_araddr == wdt_sleep_pkg::CONFIG_ADDR;
    wire rd_status = s_axi_araddr == wdt_sleep_pkg::STATUS_ADDR;
    wire rd_known  = rd_option | rd_config | rd_status;

    wire [7:0] status_byte =
        (8'(flags_r.expired) << wdt_sleep_pkg::STAT_EXPIRED_BIT)
      | (8'(flags_r.slept)   << wdt_sleep_pkg::STAT_SLEPT_BIT);
    wire [7:0] rd_byte = rd_option ? option_r
                       : rd_config ? cfg_r
                       : rd_status ? status_byte
                       : 8'h00;

    // software assigns prescaler and ratio here
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            option_r <= wdt_sleep_pkg::OPTION_RESET;
        end else if (wr_fire && wr_option && s_axi_wstrb[0]) begin
            option_r <= s_axi_wdata[7:0];
        end
    end

    // address and data are taken together once both are offered
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= wdt_sleep_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
                           & ~s_axi_bvalid;
            s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
                           & ~s_axi_bvalid;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? wdt_sleep_pkg::RESP_OKAY
                                         : wdt_sleep_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= wdt_sleep_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h00_0000, rd_byte};
                s_axi_rresp  <= rd_known ? wdt_sleep_pkg::RESP_OKAY
                                         : wdt_sleep_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// >>> testbench/wdt_sleep_props.sv
`timescale 1ns/1ns
`default_nettype none
module wdt_sleep_props (
    input wire logic       clock,              // clock
    input wire logic       rst_b,              // reset, low
    input wire logic [7:0] config_word,        // fuse byte
    input wire logic       master_clear_pin_b, // ext reset, low
    input wire logic       global_irq_enable,  // global enable
    input wire logic [8:0] wake_irq_flags,     // wake flags
    input wire logic [8:0] wake_irq_enables,   // wake enables
    input wire logic       sleep_instr,        // sleep pulse
    input wire logic       s_axi_awready,      // write taken
    input wire logic       s_axi_bvalid,       // write answer
    input wire logic       s_axi_arready,      // read taken
    input wire logic       s_axi_rvalid,       // read answer
    input wire logic       device_reset,       // reset out
    input wire logic       core_clk_run,       // core clocks on
    input wire logic       osc_drive_en,       // osc driver on
    input wire logic       io_hold,            // pins frozen
    input wire logic       prefetch_next,      // prefetch pulse
    input wire logic       resume_exec,        // resume pulse
    input wire logic       branch_to_vector,   // vector pulse
    input wire logic       dog_expired_flag,   // expired flag
    input wire logic       sleep_entered_flag  // slept flag
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // enabled source pending, wakes or blocks sleep
    wire logic pend = |(wake_irq_flags & wake_irq_enables);

    a_sleep_entry: assert property (
        sleep_instr && core_clk_run && !pend |=> !osc_drive_en
        && prefetch_next && !sleep_entered_flag && dog_expired_flag)
        else $error("sleep entry outputs wrong");
    a_sleep_noop: assert property (
        sleep_instr && core_clk_run && pend |=> osc_drive_en
        && !prefetch_next && $stable(sleep_entered_flag))
        else $error("pending irq sleep not a no-op");
    a_sleep_hold: assert property (
        !osc_drive_en |-> io_hold && !core_clk_run)
        else $error("pins not held in sleep");
    a_wake_resume: assert property (
        $rose(core_clk_run) && !device_reset |-> resume_exec)
        else $error("core restarted without resume");
    a_branch_global: assert property (
        branch_to_vector |-> resume_exec && $past(global_irq_enable))
        else $error("branch without global enable");
    a_rc_irq_wake: assert property (
        config_word[1:0] == 2'h3 && !osc_drive_en && pend
        |-> ##[1:3] resume_exec)
        else $error("enabled irq did not wake in rc mode");
    a_slept_clear: assert property (
        $fell(sleep_entered_flag) |-> $past(sleep_instr))
        else $error("slept flag cleared without sleep");
    a_dog_reset_flag: assert property (
        device_reset && $past(master_clear_pin_b)
        |-> ##[0:1] !dog_expired_flag)
        else $error("timeout reset left expired flag set");
    a_write_answer: assert property (
        s_axi_awready |=> s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (
        s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");

    c_branch: cover property (resume_exec && branch_to_vector);
    c_dog_reset: cover property (device_reset);
    c_sleep: cover property ($fell(osc_drive_en));
endmodule

bind watchdog_sleep_wake_ctrl wdt_sleep_props wdt_sleep_props_inst (
    .clock(clock), .rst_b(rst_b), .config_word(config_word),
    .master_clear_pin_b(master_clear_pin_b), .sleep_instr(sleep_instr),
    .global_irq_enable(global_irq_enable), .wake_irq_flags(wake_irq_flags),
    .wake_irq_enables(wake_irq_enables), .s_axi_awready(s_axi_awready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .device_reset(device_reset),
    .core_clk_run(core_clk_run), .osc_drive_en(osc_drive_en),
    .io_hold(io_hold), .prefetch_next(prefetch_next),
    .resume_exec(resume_exec), .branch_to_vector(branch_to_vector),
    .dog_expired_flag(dog_expired_flag),
    .sleep_entered_flag(sleep_entered_flag));
`default_nettype wire

// >>> testbench/watchdog_sleep_wake_ctrl_test.sv
`timescale 1ns/1ns
`default_nettype none
module watchdog_sleep_wake_ctrl_test;
    localparam int unsigned BASE = 16;
    localparam logic [15:0] ST = wdt_sleep_pkg::STATUS_ADDR;
    localparam logic [15:0] OP = wdt_sleep_pkg::OPTION_ADDR;
    localparam logic [15:0] CF = wdt_sleep_pkg::CONFIG_ADDR;
    localparam logic [1:0]  OKR = wdt_sleep_pkg::RESP_OKAY;
    localparam logic [1:0]  ERR = wdt_sleep_pkg::RESP_SLVERR;
    logic             clock, rst_b, s_axi_awvalid, s_axi_wvalid;
    logic             s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [15:0]      s_axi_awaddr, s_axi_araddr;
    logic [31:0]      s_axi_wdata;
    logic [3:0]       s_axi_wstrb;
    logic [7:0]       config_word, opt;
    logic             kick_dog_instr, sleep_instr, master_clear_pin_b;
    logic             global_irq_enable;
    logic [8:0]       wake_irq_flags, wake_irq_enables;
    wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire logic        s_axi_arready, s_axi_rvalid;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic        device_reset, core_clk_run, osc_drive_en, io_hold;
    wire logic        prefetch_next, resume_exec, branch_to_vector;
    wire logic [12:0] vector_addr;
    wire logic        dog_expired_flag, sleep_entered_flag;
    int               n_mismatch, checks_done, cyc, n, n_rst, m;
    logic [33:0]      rd_q[$];
    logic             wk_q[$];

    watchdog_sleep_wake_ctrl #(
        .WDT_BASE_CYCLES_P(BASE)
    ) watchdog_sleep_wake_ctrl_inst (.*);

    initial clock = 1'b0;
    always #10 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // hang guard, far above the planned run
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // results are matched against the oldest note
    always @(posedge clock) begin
        if (device_reset) n_rst++;
        if (s_axi_rvalid && s_axi_rready) begin
            check({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
        end
        if (resume_exec) check(branch_to_vector, wk_q.pop_front());
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic do_reset(input logic [7:0] cfg);
        rst_b <= 1'b0;
        config_word <= cfg;
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(posedge clock); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge clock); while (!s_axi_bvalid);
        check(s_axi_bresp, er);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] v,
                      input logic [1:0] er);
        rd_q.push_back({er, 24'h000000, v});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock); while (!s_axi_rvalid);
    endtask

    task automatic pulse(input bit slp);
        if (slp) sleep_instr <= 1'b1;
        else kick_dog_instr <= 1'b1;
        @(posedge clock);
        if (slp) sleep_instr <= 1'b0;
        else kick_dog_instr <= 1'b0;
    endtask

    // edges until reset pulse (dr) or resume
    task automatic until_ev(input bit dr);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (!(dr ? device_reset : resume_exec));
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
        {kick_dog_instr, sleep_instr, global_irq_enable} = 3'h0;
        {s_axi_bready, s_axi_rready, master_clear_pin_b} = 3'h7;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
        s_axi_wstrb = 4'hF;
        config_word = 8'h07;
        {wake_irq_flags, wake_irq_enables} = 18'h0;
        void'($urandom(18));
        do_reset(8'h07);
        check(vector_addr, 13'h0004);
        rd(ST, 8'h18, OKR);
        rd(OP, wdt_sleep_pkg::OPTION_RESET, OKR);
        rd(16'h0100, 8'h00, ERR);
        wr(16'h0100, 8'hFF, ERR);
        wr(CF, 8'h00, OKR);
        rd(CF, 8'h07, OKR);
        for (int s = 0; s < 8; s++) begin
            opt = {8'($urandom)} | 8'h08;
            opt[2:0] = 3'(s);
            wr(OP, opt, OKR);
            pulse(0);
            until_ev(1);
            check(n + 1 >= BASE << s && n <= (BASE << s) + 2, 1'b1);
            rd(ST, 8'h08, OKR);
        end
        opt = 8'($urandom) & 8'hF7;
        wr(OP, opt, OKR);
        pulse(0);
        until_ev(1);
        check(n + 1 >= BASE && n <= BASE + 2, 1'b1);
        // let the monitor count the reset pulse first
        @(posedge clock);
        m = n_rst;
        repeat (6) begin
            pulse(0);
            repeat (10) @(posedge clock);
        end
        check(n_rst, m);
        rd(OP, opt, OKR);
        wk_q.push_back(1'b0);
        pulse(1);
        rd(ST, 8'h10, OKR);
        until_ev(0);
        rd(ST, 8'h00, OKR);
        pulse(0);
        wake_irq_flags <= 9'h004;
        wake_irq_enables <= 9'h004;
        @(posedge clock);
        pulse(1);
        @(posedge clock);
        check(osc_drive_en, 1'b1);
        rd(ST, 8'h00, OKR);
        wr(OP, 8'h0F, OKR);
        wake_irq_flags <= 9'h000;
        wake_irq_enables <= 9'h000;
        for (int k = 0; k < 9; k++) begin
            global_irq_enable <= !k[0];
            pulse(0);
            pulse(1);
            wake_irq_flags <= 9'h001 << k;
            repeat (4) @(posedge clock);
            check(osc_drive_en, 1'b0);
            wk_q.push_back(!k[0]);
            wake_irq_enables <= 9'h001 << k;
            until_ev(0);
            check(n <= 3, 1'b1);
            wake_irq_flags <= 9'h000;
            wake_irq_enables <= 9'h000;
            @(posedge clock);
        end
        do_reset(8'h03);
        m = n_rst;
        pulse(1);
        repeat (200) @(posedge clock);
        check(osc_drive_en, 1'b0);
        check(n_rst, m);
        master_clear_pin_b <= 1'b0;
        repeat (3) @(posedge clock);
        check(device_reset, 1'b1);
        master_clear_pin_b <= 1'b1;
        repeat (3) @(posedge clock);
        check(core_clk_run, 1'b1);
        do_reset(8'h00);
        wk_q.push_back(1'b1);
        pulse(1);
        wake_irq_flags <= 9'h001;
        wake_irq_enables <= 9'h001;
        until_ev(0);
        check(n >= wdt_sleep_pkg::OST_CYCLES, 1'b1);
        check(n <= wdt_sleep_pkg::OST_CYCLES + 4, 1'b1);
        print_verdict();
    end
endmodule
`default_nettype wire
